// [core/rar_defs.svh]
`ifndef RAR_DEFS_SVH
`define RAR_DEFS_SVH

// Register byte addresses, full 000h..1FFh space
`define RAR_AW              9
`define RAR_A_MSR1          9'h005
`define RAR_A_FREQ_TOP      9'h007
`define RAR_A_OPSTATE       9'h009
`define RAR_A_FREQ_LOW      9'h00C
`define RAR_A_FREQ_MID      9'h00D
`define RAR_A_ISR1          9'h010
`define RAR_A_MSR4          9'h017
`define RAR_A_MCR1          9'h032
`define RAR_A_MCLK_LOW      9'h03C
`define RAR_A_MCLK_HIGH     9'h03D
`define RAR_A_HOLD_LOW      9'h03E
`define RAR_A_HOLD_MID      9'h03F
`define RAR_A_HOLD_TOP      9'h040
`define RAR_A_HLIM_LOW      9'h041
`define RAR_A_HLIM_HIGH     9'h042
`define RAR_A_DIVN_LOW      9'h046
`define RAR_A_DIVN_HIGH     9'h047
`define RAR_A_IER1          9'h05C
`define RAR_A_IER4          9'h05D
`define RAR_A_OFFS_LOW      9'h070
`define RAR_A_OFFS_HIGH     9'h071
`define RAR_A_PHASE_LOW     9'h077
`define RAR_A_PHASE_HIGH    9'h078

// Bit positions
`define RAR_B_SOFT_RST      7
`define RAR_B_MRAA          5
`define RAR_B_LOCK1         0
`define RAR_B_LOCK2         4
`define RAR_B_HOTOP_LSB     3

// Field widths
`define RAR_W_FREQ          19
`define RAR_W_16            16
`define RAR_W_HLIM          10

// Reset values
`define RAR_DEF_FIELD       24'h000000
`define RAR_DEF_HOTOP       5'h00
`define RAR_DEF_IER1        8'h00
`define RAR_DEF_IER4        1'b0
`define RAR_DEF_STRAP       3'h0

// Settling time before host initialisation, and clock rate
`define RAR_INIT_WAIT_US    100
`define RAR_CLK_MHZ         250

`endif

// [core/rar_pkg.sv]
`include "rar_defs.svh"

package rar_pkg;

	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [`RAR_AW-1:0]    addr;
		logic [7:0]            wdata;
	} rar_req_t;

	typedef struct packed {
		logic [23:0] val;
		logic [23:0] pend;
		logic [2:0]  got;
		logic [23:0] snap;
		logic [2:0]  seen;
		logic        frozen;
	} rar_mf_t;

	typedef struct packed {
		logic [7:0]  rdata;
		logic        rvalid;
		logic        soft_rst;
		logic        strap_done;
		logic [2:0]  strap_lat;
		logic [2:0]  strap_mode;
		logic [4:0]  ho_top;
		logic [7:0]  msr1;
		logic [7:0]  ev_prev;
		logic [1:0]  lock;
		logic [1:0]  lock_prev;
		logic        mraa;
		logic [7:0]  ier1;
		logic        ier4;
		logic        irq;
		logic [14:0] wait_cnt;
		logic        ready;
	} rar_st_t;

endpackage

// [core/rar_mfield.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rar_defs.svh"

module rar_mfield import rar_pkg::*; #(
	parameter int               NB = 2,
	parameter int               W  = 16,
	parameter int               RO = 0,
	parameter logic [`RAR_AW-1:0] A0 = 9'h000,
	parameter logic [`RAR_AW-1:0] A1 = 9'h000,
	parameter logic [`RAR_AW-1:0] A2 = 9'h000
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        srst_in,
	input  wire rar_req_t    req_in,
	input  wire logic [23:0] live_in,
	output logic             hit_out,
	output logic [7:0]       rbyte_out,
	output logic             abort_out,
	output logic [23:0]      val_out
);
	localparam logic [2:0]  FULL  = 3'((1 << NB) - 1);
	localparam logic [23:0] WMASK = 24'((64'h1 << W) - 64'h1);

	rar_mf_t     s_r;
	rar_mf_t     s_nxt;
	logic [2:0]  sel;
	logic        acc;
	logic [23:0] src;
	logic        wr_seq_brk;
	logic        rd_seq_brk;

	assign sel[0]     = req_in.addr == A0;
	assign sel[1]     = req_in.addr == A1;
	assign sel[2]     = (NB > 2) && (req_in.addr == A2);
	assign hit_out    = |sel;
	assign acc        = req_in.wr | req_in.rd;
	// Frozen snapshot wins over the live value so a read sequence stays coherent
	assign src        = s_r.frozen ? s_r.snap : ((RO != 0) ? live_in : s_r.val);
	assign rbyte_out  = sel[2] ? src[23:16] : (sel[1] ? src[15:8] : src[7:0]);
	assign wr_seq_brk = acc && (s_r.got != 3'h0) && !(req_in.wr && hit_out);
	assign rd_seq_brk = acc && s_r.frozen && !(req_in.rd && hit_out);
	assign abort_out  = wr_seq_brk | rd_seq_brk;
	assign val_out    = s_r.val;

	always_comb begin
		s_nxt = s_r;
		if (wr_seq_brk) begin
			s_nxt.got = 3'h0;
		end
		if (rd_seq_brk) begin
			s_nxt.frozen = 1'b0;
			s_nxt.seen   = 3'h0;
		end
		// Read-only fields never store write data, though a write still breaks a frozen read
		if (req_in.wr && hit_out && (RO == 0)) begin
			if (sel[0]) s_nxt.pend[7:0]   = req_in.wdata;
			if (sel[1]) s_nxt.pend[15:8]  = req_in.wdata;
			if (sel[2]) s_nxt.pend[23:16] = req_in.wdata;
			s_nxt.got = s_nxt.got | sel;
			if (s_nxt.got == FULL) begin
				s_nxt.val = s_nxt.pend & WMASK;
				s_nxt.got = 3'h0;
			end
		end
		if (req_in.rd && hit_out) begin
			if (!s_r.frozen) begin
				s_nxt.snap   = (RO != 0) ? live_in : s_r.val;
				s_nxt.frozen = 1'b1;
				s_nxt.seen   = sel;
			end else begin
				s_nxt.seen = s_r.seen | sel;
			end
			if (s_nxt.seen == FULL) begin
				s_nxt.frozen = 1'b0;
				s_nxt.seen   = 3'h0;
			end
		end
		// Sequence tracking belongs to the host port and survives a soft reset
		if (srst_in) begin
			s_nxt.val = `RAR_DEF_FIELD;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_MF_ABORT_WR: assert property (
		(s_r.got != 3'h0) && req_in.rd |-> abort_out ##1 (s_r.got == 3'h0))
		else $error("interrupted write did not abort");
	AST_MF_COMMIT: assert property (
		req_in.wr && hit_out && (RO == 0) && !srst_in && ((s_r.got | sel) == FULL)
		|=> (s_r.got == 3'h0) && ((s_r.val & ~WMASK) == 24'h0))
		else $error("complete write did not commit");
	AST_MF_NOCOMMIT: assert property (
		!srst_in && !(req_in.wr && hit_out && ((s_r.got | sel) == FULL)) |=> $stable(s_r.val))
		else $error("field changed without full write");
	AST_MF_FROZEN: assert property (
		s_r.frozen && req_in.rd && hit_out && sel[0] |-> rbyte_out == s_r.snap[7:0])
		else $error("frozen field returned live data");
	AST_MF_ABORT_RD: assert property (
		s_r.frozen && req_in.wr && !hit_out |-> abort_out ##1 !s_r.frozen)
		else $error("interrupted read did not unfreeze");

	COV_MF_COMMIT: cover property (req_in.wr && hit_out && ((s_r.got | sel) == FULL) && (NB > 1));
endmodule

`default_nettype wire

// [core/rar_regbank.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rar_defs.svh"

// How it works
// - Low hard reset asynchronously clears everything here; no test port logic lives here.
// - During hard reset all defaults load; strap field captures pins after release.
// - Soft reset bit resets all but host port state and itself.
// - Soft reset restores strap field from the value caught at hard reset.
// - Nine address bits decode the whole 000h..1FFh byte space.
// - Writes to read-only fields are ignored; other fields read and write.
// - Real-time status returns the monitored level present at the read.
// - Latched status sets on rising edge, clears on write one only.
// - A set latched bit with its enable set drives the interrupt request.
// - Lock event flags never interrupt and clear on written zero.
// - Every configuration field except the strap field returns to its default on any reset.
// - Multi-byte writes commit only after all bytes arrive uninterrupted.
// - An interrupted multi-byte write drops pending bytes and sets abort flag.
// - Reading one byte freezes the remaining bytes until all are read.
// - An unrelated access during a multi-byte read unfreezes and sets abort flag.
// - Measured frequency is a 19-bit read-only field at 0Ch, 0Dh, 07h.
// - Top holdover byte updates its upper five bits at once on write.
// - That same write also advances the holdover frequency sequence.
module rar_regbank import rar_pkg::*; #(
	parameter int INIT_WAIT_CYC = `RAR_INIT_WAIT_US * `RAR_CLK_MHZ
) (
	input  wire logic              MCLK_IN,
	input  wire logic              RESET_N_IN,
	input  wire logic [`RAR_AW-1:0] REG_ADDR_IN,
	input  wire logic [7:0]        REG_WDATA_IN,
	input  wire logic              REG_WR_IN,
	input  wire logic              REG_RD_IN,
	input  wire logic [2:0]        STRAP_MODE_IN,
	input  wire logic [18:0]       MEAS_FREQ_IN,
	input  wire logic [15:0]       PHASE_READOUT_IN,
	input  wire logic [7:0]        STATUS_LEVEL_IN,
	input  wire logic [7:0]        STATUS_EVENT_IN,
	input  wire logic [1:0]        LOCK_EVENT_IN,
	output logic [7:0]             REG_RDATA_OUT,
	output logic                   REG_RVALID_OUT,
	output logic                   INTERRUPT_REQUEST_OUT,
	output logic                   SOFT_RESET_OUT,
	output logic                   INIT_READY_OUT,
	output logic [2:0]             STRAP_MODE_OUT,
	output logic [15:0]            MASTER_CLOCK_TRIM_OUT,
	output logic [18:0]            HOLDOVER_FREQUENCY_OUT,
	output logic [4:0]             HOLDOVER_CONTROL_TOP_OUT,
	output logic [9:0]             HARD_LIMIT_OUT,
	output logic [15:0]            INPUT_DIVIDER_OUT,
	output logic [15:0]            PHASE_OFFSET_OUT
);
	localparam int NF = 7;
	localparam int FNB [NF] = '{3, 2, 3, 2, 2, 2, 2};
	localparam int FW  [NF] = '{`RAR_W_FREQ, `RAR_W_16, `RAR_W_FREQ, `RAR_W_HLIM,
		`RAR_W_16, `RAR_W_16, `RAR_W_16};
	localparam int FRO [NF] = '{1, 0, 0, 0, 0, 0, 1};
	localparam logic [`RAR_AW-1:0] FA0 [NF] = '{`RAR_A_FREQ_LOW, `RAR_A_MCLK_LOW,
		`RAR_A_HOLD_LOW, `RAR_A_HLIM_LOW, `RAR_A_DIVN_LOW, `RAR_A_OFFS_LOW,
		`RAR_A_PHASE_LOW};
	localparam logic [`RAR_AW-1:0] FA1 [NF] = '{`RAR_A_FREQ_MID, `RAR_A_MCLK_HIGH,
		`RAR_A_HOLD_MID, `RAR_A_HLIM_HIGH, `RAR_A_DIVN_HIGH, `RAR_A_OFFS_HIGH,
		`RAR_A_PHASE_HIGH};
	localparam logic [`RAR_AW-1:0] FA2 [NF] = '{`RAR_A_FREQ_TOP, `RAR_A_FREQ_TOP,
		`RAR_A_HOLD_TOP, `RAR_A_FREQ_TOP, `RAR_A_FREQ_TOP, `RAR_A_FREQ_TOP,
		`RAR_A_FREQ_TOP};
	localparam logic [14:0] WAIT_LAST = 15'(INIT_WAIT_CYC - 1);

	rar_st_t     s_r;
	rar_st_t     s_nxt;
	rar_req_t    req;
	logic [23:0] f_live  [NF];
	logic [23:0] f_val   [NF];
	logic [7:0]  f_byte  [NF];
	logic [NF-1:0] f_hit;
	logic [NF-1:0] f_abort;
	logic [7:0]  fld_byte;
	logic [7:0]  rd_mux;
	logic [7:0]  ev_rise;
	logic [1:0]  lock_rise;
	logic [7:0]  msr1_clr;
	logic [1:0]  lock_keep;
	logic        wr_hit;

	assign req.wr    = REG_WR_IN;
	assign req.rd    = REG_RD_IN;
	assign req.addr  = REG_ADDR_IN;
	assign req.wdata = REG_WDATA_IN;

	assign f_live[0] = {5'h00, MEAS_FREQ_IN};
	assign f_live[1] = 24'h000000;
	assign f_live[2] = 24'h000000;
	assign f_live[3] = 24'h000000;
	assign f_live[4] = 24'h000000;
	assign f_live[5] = 24'h000000;
	assign f_live[6] = {8'h00, PHASE_READOUT_IN};

	// The top holdover byte is shared: the field sees every write to it, but keeps
	// only its low three bits, while the upper five are handled here
	generate
		for (genvar i = 0; i < NF; i++) begin : g_fld
			rar_mfield #(
				.NB (FNB[i]),
				.W  (FW[i]),
				.RO (FRO[i]),
				.A0 (FA0[i]),
				.A1 (FA1[i]),
				.A2 (FA2[i])
			) u_fld (
				.clk_in    (MCLK_IN),
				.rst_n_in  (RESET_N_IN),
				.srst_in   (s_r.soft_rst),
				.req_in    (req),
				.live_in   (f_live[i]),
				.hit_out   (f_hit[i]),
				.rbyte_out (f_byte[i]),
				.abort_out (f_abort[i]),
				.val_out   (f_val[i])
			);
		end
	endgenerate

	always_comb begin
		fld_byte = 8'h00;
		for (int i = 0; i < NF; i++) begin
			if (f_hit[i]) begin
				fld_byte = f_byte[i];
			end
		end
	end

	// Unlisted and reserved locations read as zero
	always_comb begin
		if (REG_ADDR_IN == `RAR_A_HOLD_TOP) begin
			rd_mux = {s_r.ho_top, fld_byte[`RAR_B_HOTOP_LSB-1:0]};
		end else if (|f_hit) begin
			rd_mux = fld_byte;
		end else if (REG_ADDR_IN == `RAR_A_MSR1) begin
			rd_mux = s_r.msr1;
		end else if (REG_ADDR_IN == `RAR_A_OPSTATE) begin
			rd_mux = STATUS_LEVEL_IN;
		end else if (REG_ADDR_IN == `RAR_A_ISR1) begin
			rd_mux = 8'h00;
			rd_mux[`RAR_B_LOCK1] = s_r.lock[0];
			rd_mux[`RAR_B_LOCK2] = s_r.lock[1];
		end else if (REG_ADDR_IN == `RAR_A_MSR4) begin
			rd_mux = 8'h00;
			rd_mux[`RAR_B_MRAA] = s_r.mraa;
		end else if (REG_ADDR_IN == `RAR_A_MCR1) begin
			rd_mux = {5'h00, s_r.strap_mode};
			rd_mux[`RAR_B_SOFT_RST] = s_r.soft_rst;
		end else if (REG_ADDR_IN == `RAR_A_IER1) begin
			rd_mux = s_r.ier1;
		end else if (REG_ADDR_IN == `RAR_A_IER4) begin
			rd_mux = 8'h00;
			rd_mux[`RAR_B_MRAA] = s_r.ier4;
		end else begin
			rd_mux = 8'h00;
		end
	end

	// Edge memory clears low: an input already high at reset release counts as a rise
	assign ev_rise   = STATUS_EVENT_IN & ~s_r.ev_prev;
	assign lock_rise = LOCK_EVENT_IN & ~s_r.lock_prev;
	assign wr_hit    = REG_WR_IN && !s_r.soft_rst;
	assign msr1_clr  = (wr_hit && (REG_ADDR_IN == `RAR_A_MSR1)) ? REG_WDATA_IN : 8'h00;
	assign lock_keep = (wr_hit && (REG_ADDR_IN == `RAR_A_ISR1)) ?
		{REG_WDATA_IN[`RAR_B_LOCK2], REG_WDATA_IN[`RAR_B_LOCK1]} : 2'b11;

	always_comb begin
		s_nxt           = s_r;
		s_nxt.rvalid    = REG_RD_IN;
		s_nxt.ev_prev   = STATUS_EVENT_IN;
		s_nxt.lock_prev = LOCK_EVENT_IN;
		if (REG_RD_IN) begin
			s_nxt.rdata = rd_mux;
		end
		// A new edge in the same cycle as a clear keeps the flag set
		s_nxt.msr1 = (s_r.msr1 & ~msr1_clr) | ev_rise;
		s_nxt.lock = (s_r.lock & lock_keep) | lock_rise;
		if (wr_hit && (REG_ADDR_IN == `RAR_A_MSR4) && REG_WDATA_IN[`RAR_B_MRAA]) begin
			s_nxt.mraa = 1'b0;
		end
		if (|f_abort) begin
			s_nxt.mraa = 1'b1;
		end
		if (wr_hit && (REG_ADDR_IN == `RAR_A_IER1)) begin
			s_nxt.ier1 = REG_WDATA_IN;
		end
		if (wr_hit && (REG_ADDR_IN == `RAR_A_IER4)) begin
			s_nxt.ier4 = REG_WDATA_IN[`RAR_B_MRAA];
		end
		if (wr_hit && (REG_ADDR_IN == `RAR_A_HOLD_TOP)) begin
			s_nxt.ho_top = REG_WDATA_IN[7:`RAR_B_HOTOP_LSB];
		end
		if (REG_WR_IN && (REG_ADDR_IN == `RAR_A_MCR1)) begin
			s_nxt.soft_rst = REG_WDATA_IN[`RAR_B_SOFT_RST];
			if (!s_r.soft_rst) begin
				s_nxt.strap_mode = REG_WDATA_IN[2:0];
			end
		end
		// Lock flags are left out on purpose: they must never raise the request
		s_nxt.irq = (|(s_r.msr1 & s_r.ier1)) | (s_r.mraa & s_r.ier4);
		// Restarted by either reset source, so the host wait covers both
		if (!s_r.ready) begin
			if (s_r.wait_cnt == WAIT_LAST) begin
				s_nxt.ready = 1'b1;
			end else begin
				s_nxt.wait_cnt = s_r.wait_cnt + 15'h0001;
			end
		end
		// Pins are sampled once, on the first edge after hard reset is released
		if (!s_r.strap_done) begin
			s_nxt.strap_lat  = STRAP_MODE_IN;
			s_nxt.strap_mode = STRAP_MODE_IN;
			s_nxt.strap_done = 1'b1;
		end
		// Soft reset spares the host port state and its own bit
		if (s_r.soft_rst) begin
			s_nxt.strap_mode = s_r.strap_lat;
			s_nxt.ho_top     = `RAR_DEF_HOTOP;
			s_nxt.msr1       = 8'h00;
			s_nxt.lock       = 2'b00;
			s_nxt.mraa       = 1'b0;
			s_nxt.ier1       = `RAR_DEF_IER1;
			s_nxt.ier4       = `RAR_DEF_IER4;
			s_nxt.irq        = 1'b0;
			s_nxt.wait_cnt   = 15'h0000;
			s_nxt.ready      = 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign REG_RDATA_OUT            = s_r.rdata;
	assign REG_RVALID_OUT           = s_r.rvalid;
	assign INTERRUPT_REQUEST_OUT    = s_r.irq;
	assign SOFT_RESET_OUT           = s_r.soft_rst;
	assign INIT_READY_OUT           = s_r.ready;
	assign STRAP_MODE_OUT           = s_r.strap_mode;
	assign MASTER_CLOCK_TRIM_OUT    = f_val[1][15:0];
	assign HOLDOVER_FREQUENCY_OUT   = f_val[2][18:0];
	assign HOLDOVER_CONTROL_TOP_OUT = s_r.ho_top;
	assign HARD_LIMIT_OUT           = f_val[3][9:0];
	assign INPUT_DIVIDER_OUT        = f_val[4][15:0];
	assign PHASE_OFFSET_OUT         = f_val[5][15:0];

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	AST_RT_STATUS: assert property (
		REG_RD_IN && (REG_ADDR_IN == `RAR_A_OPSTATE) |=>
		REG_RVALID_OUT && (REG_RDATA_OUT == $past(STATUS_LEVEL_IN)))
		else $error("real-time status not the present level");
	AST_W1C_CLEARS: assert property (
		REG_WR_IN && (REG_ADDR_IN == `RAR_A_MSR1) && !s_r.soft_rst |=>
		((s_r.msr1 & $past(REG_WDATA_IN) & ~$past(ev_rise)) == 8'h00))
		else $error("written one did not clear latched bit");
	AST_LATCH_HOLDS: assert property (
		!(REG_WR_IN && (REG_ADDR_IN == `RAR_A_MSR1)) && !s_r.soft_rst |=>
		(($past(s_r.msr1) & ~s_r.msr1) == 8'h00))
		else $error("latched bit dropped without a write of one");
	AST_IRQ_RAISE: assert property (
		(|(s_r.msr1 & s_r.ier1)) && !s_r.soft_rst |=> INTERRUPT_REQUEST_OUT)
		else $error("enabled latched bit did not raise request");
	AST_LOCK_NO_IRQ: assert property (
		((s_r.msr1 & s_r.ier1) == 8'h00) && !(s_r.mraa && s_r.ier4) |=> !INTERRUPT_REQUEST_OUT)
		else $error("request raised without an enabled source");
	AST_LOCK_W0C: assert property (
		REG_WR_IN && (REG_ADDR_IN == `RAR_A_ISR1) && !s_r.soft_rst && (s_r.lock != 2'b00) |=>
		((s_r.lock & ~$past(lock_keep) & ~$past(lock_rise)) == 2'b00))
		else $error("written zero did not clear lock flag");
	AST_SOFT_DEFAULTS: assert property (
		s_r.soft_rst |=> (s_r.msr1 == 8'h00) && (s_r.ier1 == `RAR_DEF_IER1) &&
		(HOLDOVER_CONTROL_TOP_OUT == `RAR_DEF_HOTOP) && !INTERRUPT_REQUEST_OUT)
		else $error("soft reset left a field away from default");
	AST_STRAP_RESTORE: assert property (
		s_r.soft_rst && s_r.strap_done |=> STRAP_MODE_OUT == $past(s_r.strap_lat))
		else $error("soft reset did not restore strap field");
	AST_MRAA_STICKY: assert property (
		s_r.mraa && !s_r.soft_rst && !(REG_WR_IN && (REG_ADDR_IN == `RAR_A_MSR4)) |=> s_r.mraa)
		else $error("abort flag cleared on its own");
	AST_ABORT_SETS: assert property (
		(|f_abort) && !s_r.soft_rst |=> s_r.mraa)
		else $error("aborted sequence did not set abort flag");
	AST_HOTOP_NOW: assert property (
		REG_WR_IN && (REG_ADDR_IN == `RAR_A_HOLD_TOP) && !s_r.soft_rst |=>
		HOLDOVER_CONTROL_TOP_OUT == $past(REG_WDATA_IN[7:`RAR_B_HOTOP_LSB]))
		else $error("top holdover bits not updated at once");
	AST_HOTOP_KEEP: assert property (
		!(REG_WR_IN && (REG_ADDR_IN == `RAR_A_HOLD_TOP)) && !s_r.soft_rst |=>
		$stable(HOLDOVER_CONTROL_TOP_OUT))
		else $error("top holdover bits moved without a write");

	// The attempt at the releasing edge still sees cleared state, so these
	// wait for the reset pin to be sampled high
	AST_STRAP_CAPTURE: assert property (
		RESET_N_IN && !s_r.strap_done |=>
		s_r.strap_done && (STRAP_MODE_OUT == $past(STRAP_MODE_IN)))
		else $error("strap pins not caught after hard reset");
	AST_LATCH_SETS: assert property (
		RESET_N_IN && (ev_rise != 8'h00) && !s_r.soft_rst |=>
		((s_r.msr1 & $past(ev_rise)) == $past(ev_rise)))
		else $error("rising event did not set latched bit");
	AST_LOCK_SETS: assert property (
		RESET_N_IN && (lock_rise != 2'b00) && !s_r.soft_rst |=>
		((s_r.lock & $past(lock_rise)) == $past(lock_rise)))
		else $error("rising lock event did not set its flag");

	AST_READY_HOLD: assert property (
		!s_r.ready && (s_r.wait_cnt != WAIT_LAST) |=> !INIT_READY_OUT)
		else $error("ready raised before the settling count ran out");
	AST_READY_SET: assert property (
		!s_r.ready && (s_r.wait_cnt == WAIT_LAST) && !s_r.soft_rst |=> INIT_READY_OUT)
		else $error("ready missing after the settling count");

	AST_IRQ_ABORT: assert property (
		s_r.mraa && s_r.ier4 && !s_r.soft_rst |=> INTERRUPT_REQUEST_OUT)
		else $error("enabled abort flag did not raise request");

	AST_READ_ANSWER: assert property (
		REG_RD_IN |=> REG_RVALID_OUT)
		else $error("read not answered");
	AST_NO_STRAY_ANSWER: assert property (
		!REG_RD_IN |=> !REG_RVALID_OUT)
		else $error("answer without a read");
	AST_UPPER_ZERO: assert property (
		REG_RD_IN && REG_ADDR_IN[`RAR_AW-1] |=> REG_RDATA_OUT == 8'h00)
		else $error("unlisted upper address did not read zero");

	COV_SOFT_RESET: cover property (s_r.soft_rst ##1 !s_r.soft_rst);
	COV_IRQ:        cover property ($rose(INTERRUPT_REQUEST_OUT));
	COV_ABORT:      cover property ($rose(s_r.mraa));
	COV_HOLD_TOP:   cover property (REG_WR_IN && (REG_ADDR_IN == `RAR_A_HOLD_TOP) && f_hit[2]);
endmodule

`default_nettype wire

// [verif/rar_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rar_defs.svh"

module rar_host_model (
	input  wire logic              clk_in,
	input  wire logic [7:0]        rdata_in,
	input  wire logic              rvalid_in,
	output var  logic              wr_out,
	output var  logic              rd_out,
	output var  logic [`RAR_AW-1:0] addr_out,
	output var  logic [7:0]        wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = '0;
		wdata_out = 8'h00;
	end

	// Released lines show the inverse so a stale value never passes for a fresh one
	task automatic wr(input logic [`RAR_AW-1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
		@(negedge clk_in);
	endtask

	task automatic rd(input logic [`RAR_AW-1:0] a, output logic [7:0] d, output logic ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		// Answer is looked at mid-cycle, clear of the edge that launches it
		for (n = 0; n < 4 && !ok; n++) begin
			@(negedge clk_in);
			if (rvalid_in === 1'b1) begin
				ok = 1'b1;
				d = rdata_in;
			end
		end
	endtask
endmodule
`default_nettype wire

// [verif/reset_and_register_access_rules_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rar_defs.svh"

module reset_and_register_access_rules_tb_top import rar_pkg::*;;
	logic clk, rst_n, wr, rd, rvalid, irq, srst, ready, ok;
	logic [`RAR_AW-1:0] addr;
	logic [7:0] wdata, rdata, lvl, ev, d;
	logic [2:0] strap, strap_o;
	logic [18:0] mfreq, hofreq;
	logic [15:0] phase, mclk, divn, offs;
	logic [4:0] hotop;
	logic [9:0] hlim;
	logic [1:0] lk;
	logic [`RAR_AW-1:0] lo [3];
	int err_count, compares, i;

	rar_host_model u_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
		.rd_out(rd), .addr_out(addr), .wdata_out(wdata));

	rar_regbank #(.INIT_WAIT_CYC(20)) u_dut (.MCLK_IN(clk), .RESET_N_IN(rst_n),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.STRAP_MODE_IN(strap), .MEAS_FREQ_IN(mfreq), .PHASE_READOUT_IN(phase),
		.STATUS_LEVEL_IN(lvl), .STATUS_EVENT_IN(ev), .LOCK_EVENT_IN(lk),
		.REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .INTERRUPT_REQUEST_OUT(irq),
		.SOFT_RESET_OUT(srst), .INIT_READY_OUT(ready), .STRAP_MODE_OUT(strap_o),
		.MASTER_CLOCK_TRIM_OUT(mclk), .HOLDOVER_FREQUENCY_OUT(hofreq),
		.HOLDOVER_CONTROL_TOP_OUT(hotop), .HARD_LIMIT_OUT(hlim),
		.INPUT_DIVIDER_OUT(divn), .PHASE_OFFSET_OUT(offs));

	task automatic final_report;
		$display("Counts: %0d compares, %0d mismatches", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdchk(input logic [`RAR_AW-1:0] a, input logic [7:0] e);
		u_host.rd(a, d, ok);
		if (!ok) begin
			err_count++;
			$display("[ERR] %0t: read answer missing", $time);
			final_report();
		end else
			check(d, e);
	endtask

	// Host may not initialise before the settling count has run out
	task automatic wait_ready;
		int n;
		for (n = 0; n < 100 && ready !== 1'b1; n++)
			@(negedge clk);
		if (ready !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t: ready never rose", $time);
			final_report();
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		strap = 3'h5;
		mfreq = 19'h5A3C1;
		phase = 16'hBEEF;
		lvl = 8'hA5;
		ev = 8'h00;
		lk = 2'b00;
		err_count = 0;
		compares = 0;
		lo = '{9'h041, 9'h046, 9'h070};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		wait_ready();
		check(strap_o, 3'h5);
		check(mclk, 16'h0000);
		u_host.wr(9'h009, 8'h00);
		rdchk(9'h009, 8'hA5);
		@(posedge clk);
		lvl <= 8'h3C;
		rdchk(9'h009, 8'h3C);
		rdchk(9'h078, 8'hBE);
		rdchk(9'h077, 8'hEF);
		$display("Test status done");
		u_host.wr(9'h03D, 8'h12);
		check(mclk, 16'h0000);
		u_host.wr(9'h03C, 8'h34);
		check(mclk, 16'h1234);
		rdchk(9'h017, 8'h00);
		u_host.wr(9'h03C, 8'h56);
		rdchk(9'h009, 8'h3C);
		u_host.wr(9'h03D, 8'h78);
		check(mclk, 16'h1234);
		rdchk(9'h017, 8'h20);
		u_host.wr(9'h017, 8'h00);
		rdchk(9'h017, 8'h20);
		u_host.wr(9'h017, 8'h20);
		rdchk(9'h017, 8'h00);
		for (i = 0; i < 3; i++) begin
			u_host.wr(lo[i], 8'h5A);
			u_host.wr(lo[i] + 9'h001, 8'hF7);
			rdchk(lo[i], 8'h5A);
			rdchk(lo[i] + 9'h001, (i == 0) ? 8'h03 : 8'hF7);
		end
		check(hlim, 10'h35A);
		check(divn, 16'hF75A);
		check(offs, 16'hF75A);
		$display("Test multi-byte write done");
		u_host.wr(9'h040, 8'hF9);
		check(hotop, 5'h1F);
		check(hofreq, 19'h00000);
		rdchk(9'h009, 8'h3C);
		u_host.wr(9'h03E, 8'h11);
		u_host.wr(9'h03F, 8'h22);
		u_host.wr(9'h040, 8'h0B);
		check(hotop, 5'h01);
		check(hofreq, 19'h32211);
		u_host.wr(9'h017, 8'h20);
		rdchk(9'h00C, 8'hC1);
		@(posedge clk);
		mfreq <= 19'h00000;
		rdchk(9'h00D, 8'hA3);
		rdchk(9'h007, 8'h05);
		rdchk(9'h00C, 8'h00);
		rdchk(9'h009, 8'h3C);
		rdchk(9'h017, 8'h20);
		u_host.wr(9'h017, 8'h20);
		$display("Test holdover and freeze done");
		@(posedge clk);
		ev <= 8'h01;
		rdchk(9'h005, 8'h01);
		u_host.wr(9'h005, 8'h00);
		rdchk(9'h005, 8'h01);
		u_host.wr(9'h05C, 8'h01);
		repeat (2) @(negedge clk);
		check(irq, 1'b1);
		u_host.wr(9'h005, 8'h01);
		repeat (2) @(negedge clk);
		check(irq, 1'b0);
		rdchk(9'h005, 8'h00);
		@(posedge clk);
		lk <= 2'b01;
		u_host.wr(9'h05D, 8'h20);
		rdchk(9'h010, 8'h01);
		check(irq, 1'b0);
		u_host.wr(9'h010, 8'h01);
		rdchk(9'h010, 8'h01);
		u_host.wr(9'h010, 8'h00);
		rdchk(9'h010, 8'h00);
		$display("Test latched status done");
		@(posedge clk);
		strap <= 3'h2;
		u_host.wr(9'h032, 8'h80);
		repeat (2) @(negedge clk);
		check(srst, 1'b1);
		check(mclk, 16'h0000);
		check(hotop, 5'h00);
		check(strap_o, 3'h5);
		u_host.wr(9'h03C, 8'hAA);
		u_host.wr(9'h03D, 8'hBB);
		check(mclk, 16'h0000);
		u_host.wr(9'h032, 8'h05);
		check(ready, 1'b0);
		wait_ready();
		check(srst, 1'b0);
		u_host.wr(9'h03C, 8'h9A);
		u_host.wr(9'h03D, 8'hBC);
		check(mclk, 16'hBC9A);
		$display("Test soft reset done");
		// Looked at before the next edge: the clear must not wait for a clock
		@(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		check(mclk, 16'h0000);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wait_ready();
		check(strap_o, 3'h2);
		u_host.wr(9'h1FF, 8'h00);
		rdchk(9'h1FF, 8'h00);
		u_host.wr(9'h180, 8'h00);
		rdchk(9'h180, 8'h00);
		$display("Test hard reset done");
		final_report();
	end
endmodule
`default_nettype wire
